// *** src/dlp_pkg.sv ***
package dlp_pkg;

  localparam int WIPER_W = 6;
  localparam int BYTE_W = 8;
  localparam int ATTEN_W = 8;

  // Wiper codes: taps 0..32, code 33 is mute
  localparam logic [5:0] MUTE_CODE = 6'h21;
  localparam logic [5:0] WIPER_RESET = 6'h21;
  localparam logic [5:0] LAST_TAP = 6'h20;

  // Taper breakpoints in tap numbers and in dB
  localparam logic [7:0] SEG1_END_TAP = 8'h0C;
  localparam logic [7:0] SEG2_END_TAP = 8'h18;
  localparam logic [7:0] SEG1_END_DB = 8'h0C;
  localparam logic [7:0] SEG2_END_DB = 8'h24;
  localparam logic [7:0] SEG2_STEP_DB = 8'h02;
  localparam logic [7:0] SEG3_STEP_DB = 8'h03;
  // Mute is deeper than any tap; reported as all ones
  localparam logic [7:0] MUTE_ATTEN = 8'hFF;

  // Addressing byte field positions
  localparam int RW_BIT = 0;
  localparam int SEL_LSB = 1;
  localparam int TYPE_LSB = 4;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef struct packed {
    logic scl;
    logic sda;
    logic gate_n;
  } dlp_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WR_DATA,
    ST_WR_ACK,
    ST_RD_DATA,
    ST_RD_ACK
  } dlp_state_t;

  function automatic logic [7:0] dlp_atten(input logic [5:0] tap);
    logic [7:0] t;
    t = {2'h0, tap};
    if (tap > LAST_TAP)
      dlp_atten = MUTE_ATTEN;
    else if (t <= SEG1_END_TAP)
      dlp_atten = t;
    else if (t <= SEG2_END_TAP)
      dlp_atten = SEG1_END_DB + (t - SEG1_END_TAP) * SEG2_STEP_DB;
    else
      dlp_atten = SEG2_END_DB + (t - SEG2_END_TAP) * SEG3_STEP_DB;
  endfunction

endpackage

// *** src/dlp_pot_slave.sv ***
// Function
// - Two independent channels of 33 taps plus mute; own register each.
// - 6-bit position register per channel, set only over the serial port.
// - Reset loads both position registers with mute code 33.
// - 34 selections per channel; the last is mute, deepest attenuation.
// - Taps map 1 dB steps for 12, 2 dB for 12, 3 dB for 8.
// - Sample data on clock rises; change outgoing data after clock falls.
// - Data line driven open-drain only: pull low or release.
// - Port gate low enables the port; high ignores clock and data.
// - Three select pins set the bus address, up to eight devices.
// - Slave only; never drives the clock, never makes start or stop.
// - Last addressing bit one means read, zero means write.
// - Acknowledge address only when type code and select bits match.
// - Read returns channel 0 then 1; a master not-acknowledge ends it.
// - All bytes go MSB first; the receiving side gives the acknowledge.
`timescale 1ns/1ps
`default_nettype none

module dlp_pot_slave
  import dlp_pkg::*;
#(
  // Device type code; value is arbitrary
  parameter logic [3:0] TYPE_CODE = 4'hA
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_port_gate_n,
  input wire logic i_bus_addr_sel_bit0,
  input wire logic i_bus_addr_sel_bit1,
  input wire logic i_bus_addr_sel_bit2,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic [dlp_pkg::WIPER_W-1:0] o_tap_out_ch0,
  output logic [dlp_pkg::WIPER_W-1:0] o_tap_out_ch1,
  output logic [dlp_pkg::ATTEN_W-1:0] o_atten_db_ch0,
  output logic [dlp_pkg::ATTEN_W-1:0] o_atten_db_ch1
);
  import dlp_pkg::*;

  dlp_pins_t pin_meta_q;
  dlp_pins_t pin_sync_q;
  dlp_pins_t pin_prev_q;
  dlp_pins_t pin_raw;
  dlp_state_t state_q;
  dlp_state_t state_d;
  logic [2:0] bit_cnt_q;
  logic full_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic rw_q;
  logic ptr_q;
  logic more_q;
  logic sda_oe_q;
  logic [5:0] wiper0_q;
  logic [5:0] wiper1_q;
  logic [7:0] atten0_q;
  logic [7:0] atten1_q;
  logic [2:0] sel_meta_q;
  logic [2:0] sel_sync_q;

  // Pins cross into the reference clock through two flops; the link
  // clock is only sampled, so it needs a few reference cycles per level
  assign pin_raw = '{scl: i_scl, sda: i_sda, gate_n: i_port_gate_n};

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      pin_meta_q <= '{scl: 1'b1, sda: 1'b1, gate_n: 1'b1};
      pin_sync_q <= '{scl: 1'b1, sda: 1'b1, gate_n: 1'b1};
      pin_prev_q <= '{scl: 1'b1, sda: 1'b1, gate_n: 1'b1};
      sel_meta_q <= 3'h0;
      sel_sync_q <= 3'h0;
    end
    else
    begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
      sel_meta_q <= {i_bus_addr_sel_bit2, i_bus_addr_sel_bit1,
                     i_bus_addr_sel_bit0};
      sel_sync_q <= sel_meta_q;
    end
  end

  wire port_on = !pin_sync_q.gate_n;
  wire scl_rise = port_on && pin_sync_q.scl && !pin_prev_q.scl;
  wire scl_fall = port_on && !pin_sync_q.scl && pin_prev_q.scl;
  // Start and stop only seen, never made
  wire scl_high = pin_sync_q.scl && pin_prev_q.scl;
  wire bus_start = port_on && scl_high && pin_prev_q.sda && !pin_sync_q.sda;
  wire bus_stop = port_on && scl_high && !pin_prev_q.sda && pin_sync_q.sda;
  // Straps are synchronised too, so a strap moved mid-byte cannot glitch
  wire type_hit = shift_q[TYPE_LSB +: 4] == TYPE_CODE;
  wire sel_hit = shift_q[SEL_LSB +: 3] == sel_sync_q;
  wire addr_match = type_hit && sel_hit;
  wire is_read = shift_q[RW_BIT];
  // Out-of-range codes are forced to mute
  wire [5:0] rx_code = (shift_q[7:6] != 2'h0 || shift_q[5:0] > MUTE_CODE)
                       ? MUTE_CODE : shift_q[5:0];
  wire [7:0] rd_byte0 = {2'h0, wiper0_q};
  wire [7:0] rd_byte1 = {2'h0, wiper1_q};
  wire byte_end = scl_fall && full_q;
  // A third written byte is refused with a not-acknowledge
  wire wr_take = byte_end && (state_q == ST_WR_DATA) && !ptr_q;
  wire wr_take_last = byte_end && (state_q == ST_WR_DATA) && ptr_q && !more_q;

  always_comb
  begin
    state_d = state_q;
    if (!port_on || bus_stop)
      state_d = ST_IDLE;
    else if (bus_start)
      state_d = ST_ADDR;
    else if (scl_fall)
    begin
      unique case (state_q)
        ST_IDLE: state_d = ST_IDLE;
        ST_ADDR:
          if (full_q)
            state_d = addr_match ? ST_ADDR_ACK : ST_IDLE;
        ST_ADDR_ACK: state_d = rw_q ? ST_RD_DATA : ST_WR_DATA;
        ST_WR_DATA:
          if (full_q)
            state_d = (wr_take || wr_take_last) ? ST_WR_ACK : ST_IDLE;
        ST_WR_ACK: state_d = ST_WR_DATA;
        ST_RD_DATA:
          if (full_q)
            state_d = ST_RD_ACK;
        ST_RD_ACK: state_d = more_q ? ST_RD_DATA : ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // Receive shifter and bit count, MSB first on rising edges
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n || bus_start || !port_on)
    begin
      bit_cnt_q <= 3'h0;
      full_q <= 1'b0;
      shift_q <= 8'h00;
    end
    else if (scl_rise && (state_q == ST_ADDR || state_q == ST_WR_DATA
                          || state_q == ST_RD_DATA))
    begin
      shift_q <= {shift_q[6:0], pin_sync_q.sda};
      bit_cnt_q <= bit_cnt_q + 3'h1;
      full_q <= (bit_cnt_q == LAST_BIT);
    end
    else if (byte_end)
    begin
      full_q <= 1'b0;
      bit_cnt_q <= 3'h0;
    end
  end

  // Direction, byte pointer and the master acknowledge
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n || bus_start)
    begin
      rw_q <= 1'b0;
      ptr_q <= 1'b0;
      more_q <= 1'b0;
    end
    else
    begin
      if (state_q == ST_ADDR && byte_end)
        rw_q <= is_read;
      if (state_q == ST_WR_ACK && scl_fall)
      begin
        more_q <= ptr_q;
        ptr_q <= 1'b1;
      end
      // Ack after byte 0 asks for byte 1; anything else ends the read
      if (state_q == ST_RD_ACK && scl_rise)
        more_q <= !pin_sync_q.sda && !ptr_q;
      if (state_q == ST_RD_ACK && scl_fall)
        ptr_q <= 1'b1;
    end
  end

  // Transmit byte and open-drain drive, changed on falling edges, cleared on start, stop or gate high
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n || !port_on || bus_start || bus_stop)
    begin
      sda_oe_q <= 1'b0;
      tx_q <= 8'h00;
    end
    else if (scl_fall)
    begin
      unique case (state_q)
        ST_ADDR:
          sda_oe_q <= full_q && addr_match;
        ST_ADDR_ACK:
          if (rw_q)
          begin
            tx_q <= rd_byte0;
            sda_oe_q <= !rd_byte0[7];
          end
          else
            sda_oe_q <= 1'b0;
        ST_WR_DATA:
          sda_oe_q <= wr_take || wr_take_last;
        ST_WR_ACK:
          sda_oe_q <= 1'b0;
        ST_RD_DATA:
          if (full_q)
            sda_oe_q <= 1'b0;
          else
          begin
            tx_q <= {tx_q[6:0], 1'b0};
            sda_oe_q <= !tx_q[6];
          end
        ST_RD_ACK:
          if (more_q)
          begin
            tx_q <= rd_byte1;
            sda_oe_q <= !rd_byte1[7];
          end
          else
            sda_oe_q <= 1'b0;
        ST_IDLE:
          sda_oe_q <= 1'b0;
      endcase
    end
  end

  // Wiper registers: mute from reset, loaded only by serial writes
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      wiper0_q <= WIPER_RESET;
      wiper1_q <= WIPER_RESET;
    end
    else if (wr_take)
      wiper0_q <= rx_code;
    else if (wr_take_last)
      wiper1_q <= rx_code;
  end

  // Attenuation readout lags the wiper by one cycle
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      atten0_q <= MUTE_ATTEN;
      atten1_q <= MUTE_ATTEN;
    end
    else
    begin
      atten0_q <= dlp_atten(wiper0_q);
      atten1_q <= dlp_atten(wiper1_q);
    end
  end
  // Output low only; a release lets the pull-up take the line
  always_ff @(posedge i_ref_clk)
  begin
    o_sda_out <= 1'b0;
  end
  assign o_sda_oe = sda_oe_q;
  assign o_tap_out_ch0 = wiper0_q;
  assign o_tap_out_ch1 = wiper1_q;
  assign o_atten_db_ch0 = atten0_q;
  assign o_atten_db_ch1 = atten1_q;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_addr_hit;
    state_q == ST_ADDR && byte_end && addr_match;
  endsequence
  sequence s_addr_miss;
    state_q == ST_ADDR && byte_end && !addr_match;
  endsequence
  sequence s_ack_then_read;
    state_q == ST_ADDR_ACK && scl_fall && rw_q;
  endsequence
  chk_reset_mute: assert property (
    disable iff (1'b0)
    !i_rst_n |=> wiper0_q == MUTE_CODE && wiper1_q == MUTE_CODE)
    else $error("wipers not mute after reset");
  chk_gate_release: assert property (
    pin_sync_q.gate_n |=> !o_sda_oe && state_q == ST_IDLE)
    else $error("port active while gate is high");
  chk_drive_low_only: assert property (
    ##1 o_sda_out == 1'b0)
    else $error("data line driven high");
  chk_addr_ack_on: assert property (
    s_addr_hit |=> o_sda_oe && state_q == ST_ADDR_ACK)
    else $error("matching address not acknowledged");
  chk_addr_miss_off: assert property (
    s_addr_miss |=> !o_sda_oe && state_q == ST_IDLE)
    else $error("foreign address acknowledged");
  chk_oe_on_fall: assert property (
    $changed(sda_oe_q) |->
      $past(scl_fall || bus_start || bus_stop || !port_on))
    else $error("data line changed away from a falling edge");
  chk_read_first: assert property (
    s_ack_then_read |=> tx_q == {2'h0, $past(wiper0_q)}
      && state_q == ST_RD_DATA)
    else $error("read did not start with channel 0");
  chk_write_dir: assert property (
    state_q == ST_ADDR_ACK && scl_fall && !rw_q && port_on
      && !bus_start && !bus_stop |=> state_q == ST_WR_DATA)
    else $error("write direction not followed");
  chk_msb_order: assert property (
    state_q == ST_RD_DATA && scl_fall && !full_q && port_on && !bus_start
      && !bus_stop |=> o_sda_oe == !$past(tx_q[6]))
    else $error("transmit bit order wrong");
  chk_write_ch0: assert property (
    wr_take |=> wiper0_q == $past(rx_code) ##1 o_atten_db_ch0 ==
      dlp_atten($past(wiper0_q)))
    else $error("channel 0 write or taper lookup wrong");
  chk_code_range: assert property (
    wiper0_q <= MUTE_CODE && wiper1_q <= MUTE_CODE)
    else $error("wiper code beyond mute");
  chk_mute_atten: assert property (
    wiper1_q == MUTE_CODE ##1 wiper1_q == MUTE_CODE |->
      o_atten_db_ch1 == MUTE_ATTEN)
    else $error("mute attenuation not reported");
endmodule

`default_nettype wire

// *** dv/dlp_master.sv ***
`timescale 1ns/1ps
`default_nettype none

module dlp_master (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  // Bus idles high; the clock stands still between frames
  initial
  begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // Start or repeated start; only the master makes them
  task automatic start();
    o_sda_low = 1'b0;
    tick(3);
    o_scl = 1'b1;
    tick(3);
    o_sda_low = 1'b1;
    tick(3);
    o_scl = 1'b0;
    tick(2);
  endtask

  task automatic stop();
    o_sda_low = 1'b1;
    tick(3);
    o_scl = 1'b1;
    tick(3);
    o_sda_low = 1'b0;
    tick(4);
  endtask

  // Low 5 cycles, high 3: data moves well clear of both edges
  task automatic bitx(input logic b, output logic r);
    o_sda_low = ~b;
    tick(3);
    o_scl = 1'b1;
    tick(3);
    r = i_sda;
    o_scl = 1'b0;
    tick(2);
  endtask

  // MSB first, slave acks on the ninth clock
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask

  // Master receiving gives the ack, or not on the last byte
  task automatic get(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, d[i]);
    bitx(~ack, r);
  endtask
endmodule

`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb;
  import dlp_pkg::*;
  // Type code value is arbitrary
  localparam logic [3:0] TC = 4'h9;
  localparam logic [7:0] T0 [4] = '{8'h00, 8'h0C, 8'h18, 8'h21};
  localparam logic [7:0] T1 [4] = '{8'h20, 8'h0D, 8'h19, 8'h3F};
  localparam logic [7:0] E1 [4] = '{8'h20, 8'h0D, 8'h19, 8'h21};
  localparam logic [7:0] D0 [4] = '{8'h00, 8'h0C, 8'h24, 8'hFF};
  localparam logic [7:0] D1 [4] = '{8'h3C, 8'h0E, 8'h27, 8'hFF};
  logic clk, rst_n, gate_n, scl, sda_low, sda_oe, sda_out;
  logic [2:0] sel;
  logic [5:0] tap0, tap1;
  logic [7:0] db0, db1;
  wire logic sda;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;

  assign sda = ~(sda_low | sda_oe);

  dlp_pot_slave #(.TYPE_CODE(TC)) i_dlp_pot_slave (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda),
    .i_port_gate_n(gate_n), .i_bus_addr_sel_bit0(sel[0]),
    .i_bus_addr_sel_bit1(sel[1]), .i_bus_addr_sel_bit2(sel[2]),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_tap_out_ch0(tap0),
    .o_tap_out_ch1(tap1), .o_atten_db_ch0(db0), .o_atten_db_ch1(db1)
  );

  dlp_master i_dlp_master (
    .i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d fails %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Sends address then n bytes; returns acks, bit 0 for the address
  task automatic wr(input logic [7:0] ad, input int n,
    input logic [7:0] b0, input logic [7:0] b1, output logic [3:0] a);
    a = 4'h0;
    i_dlp_master.start();
    i_dlp_master.put(ad, a[0]);
    for (int i = 0; i < n; i++)
      i_dlp_master.put(i == 0 ? b0 : b1, a[i + 1]);
    i_dlp_master.stop();
  endtask

  task automatic chk_taps(input logic [7:0] e0, input logic [7:0] e1);
    chk({2'h0, tap0}, e0);
    chk({2'h0, tap1}, e1);
  endtask

  task automatic s_reset();
    chk_taps(8'h21, 8'h21);
    chk(db0, 8'hFF);
    chk({7'h0, sda_oe}, 8'h00);
  endtask

  // Third byte is refused, so channel 1 keeps the second byte
  task automatic s_taper();
    logic [3:0] a;
    logic [7:0] r0, r1;
    logic ra;
    for (int i = 0; i < 4; i++)
    begin
      wr({TC, sel, 1'b0}, 3, T0[i], T1[i], a);
      chk({4'h0, a}, 8'h07);
      chk_taps(T0[i], E1[i]);
      chk(db0, D0[i]);
      chk(db1, D1[i]);
      i_dlp_master.start();
      i_dlp_master.put({TC, sel, 1'b1}, ra);
      i_dlp_master.get(1'b1, r0);
      i_dlp_master.get(1'b0, r1);
      i_dlp_master.stop();
      chk({7'h0, ra}, 8'h01);
      chk(r0, T0[i]);
      chk(r1, E1[i]);
    end
  endtask

  task automatic s_one_byte();
    logic [3:0] a;
    wr({TC, sel, 1'b0}, 1, 8'h05, 8'h00, a);
    chk({4'h0, a}, 8'h03);
    chk_taps(8'h05, 8'h21);
  endtask

  // Every strap setting, each with a near-miss address and an inverted type
  task automatic s_addr();
    logic [3:0] a;
    for (int k = 0; k < 8; k++)
    begin
      sel = k[2:0];
      wr({TC, sel, 1'b0}, 1, {5'h0, sel}, 8'h00, a);
      chk({4'h0, a}, 8'h03);
      wr({TC, sel ^ 3'h2, 1'b0}, 1, 8'h1F, 8'h00, a);
      chk({4'h0, a}, 8'h00);
      wr({~TC, sel, 1'b0}, 1, 8'h1F, 8'h00, a);
      chk({4'h0, a}, 8'h00);
      chk({2'h0, tap0}, {5'h0, sel});
    end
  endtask

  task automatic s_gate();
    logic [3:0] a;
    gate_n = 1'b1;
    wr({TC, sel, 1'b0}, 1, 8'h0A, 8'h00, a);
    chk({4'h0, a}, 8'h00);
    gate_n = 1'b0;
    chk({2'h0, tap0}, 8'h07);
  endtask

  // The pin may only ever be pulled low; looked at mid-cycle, clear of
  // the edge that launches the drive
  always @(negedge clk)
    if (sda_oe === 1'b1)
      chk({7'h0, sda_out}, 8'h00);

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fail_count++;
      $display("[FAIL] %0t run did not finish", $time);
      final_report();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    gate_n = 1'b0;
    sel = 3'h3;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    s_reset();
    s_taper();
    s_one_byte();
    s_addr();
    s_gate();
    final_report();
  end
endmodule

`default_nettype wire
